// ### src/sbtc_top.sv
// Sixteen-bit timer/counter with AXI4-Lite register access.
// Assumes i_sys_clk is the instruction clock and pin inputs are asynchronous.
// Contract
// - Control bit 7 selects buffered 16-bit access
// - Bit 6 shows system clock from oscillator
// - Bits 5-4 prescale 1:1 to 1:8
// - Bit 3 switches crystal oscillator on
// - Bit 2 bypasses external input synchroniser
// - Bit 1 picks instruction clock or external
// - Bit 0 runs counter; stopped holds value
// - Oscillator on forces pins input, read zero
// - Oscillator keeps running in every power mode
// - Wrap FFFFh to 0000h sets overflow flag
// - Interrupt only while overflow enable set
// - Special event trigger zeroes counter, starts conversion
// - Special event reset never sets overflow
// - Special reset skipped in unsynchronised counting
// - Software write beats special event reset
// - Low read copies high byte to buffer
// - Low write loads high byte from buffer
// - Wide mode high address reaches buffer only
// - Low write clears prescaler, high write not
`timescale 1ns/1ps
`default_nettype none
module sbtc_top
  import sbtc_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_arst_n,
  input  wire logic [sbtc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                   i_s_axi_awvalid,
  output logic                        o_s_axi_awready,
  input  wire logic [31:0]            i_s_axi_wdata,
  input  wire logic [3:0]             i_s_axi_wstrb,
  input  wire logic                   i_s_axi_wvalid,
  output logic                        o_s_axi_wready,
  output logic [1:0]                  o_s_axi_bresp,
  output logic                        o_s_axi_bvalid,
  input  wire logic                   i_s_axi_bready,
  input  wire logic [sbtc_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                   i_s_axi_arvalid,
  output logic                        o_s_axi_arready,
  output logic [31:0]                 o_s_axi_rdata,
  output logic [1:0]                  o_s_axi_rresp,
  output logic                        o_s_axi_rvalid,
  input  wire logic                   i_s_axi_rready,
  input  wire logic                   i_crystal_in_pin,
  output logic                        o_crystal_in_pin,
  output logic                        o_crystal_in_pin_oe_n,
  input  wire logic                   i_crystal_out_pin,
  output logic                        o_crystal_out_pin,
  output logic                        o_crystal_out_pin_oe_n,
  input  wire logic [1:0]             i_port_dir_input,
  input  wire logic [1:0]             i_port_latch,
  output logic [1:0]                  o_port_read,
  input  wire logic                   i_osc_clk,
  output logic                        o_crystal_osc_enable,
  input  wire logic                   i_sysclk_from_timer_osc,
  input  wire logic [3:0]             i_compare_unit_mode,
  input  wire logic                   i_compare_trigger,
  input  wire logic                   i_adc_enable,
  output logic                        o_adc_start,
  output logic                        o_overflow_flag,
  output logic                        o_overflow_irq
);
  import sbtc_pkg::*;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic [15:0]       count;
    logic [7:0]        hbuf;
    logic [2:0]        presc;
    logic              ovf;
    logic              ovf_ie;
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
  } sbtc_state_t;

  sbtc_state_t st_reg;
  sbtc_state_t st_next;

  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       osc_on;
  logic       wide;
  logic       ext_src;
  logic       unsync;
  logic       in_tick;
  logic       presc_tick;
  logic       special_rst;
  logic       do_write;
  logic       do_read;
  logic       wr_low;
  logic       wr_high;
  logic [2:0] presc_top;
  logic [15:0] inc_val;
  logic       wrap;
  logic [3:0] sysclk_osc_sync;

  sbtc_edge_if ext_edge ();

  // Reset is released through two flops; assertion stays asynchronous
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign wide    = st_reg.ctrl[BIT_WIDE_ACCESS];
  assign osc_on  = st_reg.ctrl[BIT_OSC_EN];
  assign ext_src = st_reg.ctrl[BIT_SRC_SEL];
  assign unsync  = ext_src & st_reg.ctrl[BIT_SYNC_DIS];

  // Oscillator enable ignores sleep and idle by design
  assign o_crystal_osc_enable = osc_on;

  // Pins turn to inputs and read zero while the oscillator owns them
  assign o_crystal_in_pin       = i_port_latch[1];
  assign o_crystal_out_pin      = i_port_latch[0];
  assign o_crystal_in_pin_oe_n  = osc_on | i_port_dir_input[1];
  assign o_crystal_out_pin_oe_n = osc_on | i_port_dir_input[0];
  assign o_port_read = osc_on ? 2'h0 : {sysclk_osc_sync[3], sysclk_osc_sync[2]};

  // Port readback of the two pins and the oscillator system clock flag, three flops each as for any pin input
  logic [2:0] pin_in_sync_reg;
  logic [2:0] pin_out_sync_reg;
  logic [2:0] runflag_sync_reg;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_in_sync_reg  <= 3'h0;
      pin_out_sync_reg <= 3'h0;
      runflag_sync_reg <= 3'h0;
      sysclk_osc_sync  <= 4'h0;
    end else begin
      pin_in_sync_reg  <= {pin_in_sync_reg[1:0], i_crystal_in_pin};
      pin_out_sync_reg <= {pin_out_sync_reg[1:0], i_crystal_out_pin};
      runflag_sync_reg <= {runflag_sync_reg[1:0], i_sysclk_from_timer_osc};
      if (pin_in_sync_reg[1] == pin_in_sync_reg[2]) begin
        sysclk_osc_sync[3] <= pin_in_sync_reg[2];
      end
      if (pin_out_sync_reg[1] == pin_out_sync_reg[2]) begin
        sysclk_osc_sync[2] <= pin_out_sync_reg[2];
      end
      if (runflag_sync_reg[1] == runflag_sync_reg[2]) begin
        sysclk_osc_sync[0] <= runflag_sync_reg[2];
      end
      sysclk_osc_sync[1] <= 1'b0;
    end
  end

  // External count clock: oscillator output when enabled, else the pin
  assign ext_edge.raw         = osc_on ? i_osc_clk : i_crystal_out_pin;
  assign ext_edge.sync_bypass = st_reg.ctrl[BIT_SYNC_DIS];

  sbtc_edge u_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .edge_bus  (ext_edge)
  );

  // Sync bit only matters with the external source selected
  assign in_tick = ext_src ? ext_edge.rise : 1'b1;

  always_comb begin
    unique case (st_reg.ctrl[BIT_PRESC_HI:BIT_PRESC_LO])
      2'h0: presc_top = 3'h0;
      2'h1: presc_top = 3'h1;
      2'h2: presc_top = 3'h3;
      2'h3: presc_top = 3'h7;
    endcase
  end
  assign presc_tick = st_reg.ctrl[BIT_RUN] & in_tick & (st_reg.presc == presc_top);

  // Unsynchronised counting cannot promise the reset, so it is dropped there
  assign special_rst = i_compare_trigger & (i_compare_unit_mode == SPECIAL_EVENT_MODE)
                     & ~unsync;
  assign o_adc_start = i_compare_trigger & (i_compare_unit_mode == SPECIAL_EVENT_MODE)
                     & i_adc_enable;

  assign do_write = st_reg.aw_full & st_reg.w_full & ~st_reg.bvalid;
  assign do_read  = i_s_axi_arvalid & ~st_reg.rvalid;
  assign wr_low   = do_write & st_reg.w_lane0 & (st_reg.aw_addr == OFS_COUNT_LOW);
  assign wr_high  = do_write & st_reg.w_lane0 & (st_reg.aw_addr == OFS_COUNT_HIGH);

  assign inc_val = st_reg.count + 16'h0001;
  assign wrap    = presc_tick & (st_reg.count == COUNT_MAX);

  always_comb begin
    st_next = st_reg;

    // Prescaler: counts input ticks while running, cleared by low writes only
    if (st_reg.ctrl[BIT_RUN] & in_tick) begin
      st_next.presc = (st_reg.presc == presc_top) ? PRESC_RESET : st_reg.presc + 3'h1;
    end
    if (wr_low) begin
      st_next.presc = PRESC_RESET;
    end

    // Counter: increment, then special reset, then software write on top
    if (presc_tick) begin
      st_next.count = inc_val;
    end
    if (special_rst) begin
      st_next.count = COUNT_RESET;
    end
    if (wr_low) begin
      st_next.count[7:0] = st_reg.w_data;
      if (wide) begin
        st_next.count[15:8] = st_reg.hbuf;
      end
    end
    if (wr_high) begin
      if (wide) begin
        st_next.hbuf = st_reg.w_data;
      end else begin
        st_next.count[15:8] = st_reg.w_data;
      end
    end

    // Write channel capture; address and data may come in either order
    if (i_s_axi_awvalid & ~st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid & ~st_reg.w_full) begin
      st_next.w_full  = 1'b1;
      st_next.w_data  = i_s_axi_wdata[7:0];
      st_next.w_lane0 = i_s_axi_wstrb[0];
    end
    if (do_write) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = RESP_OKAY;
      unique case (st_reg.aw_addr)
        OFS_CONTROL: begin
          if (st_reg.w_lane0) begin
            st_next.ctrl = st_reg.w_data & CONTROL_WMASK;
          end
        end
        OFS_FLAGS: begin
          if (st_reg.w_lane0 & st_reg.w_data[BIT_OVERFLOW]) begin
            st_next.ovf = 1'b0;
          end
        end
        OFS_IRQ_EN: begin
          if (st_reg.w_lane0) begin
            st_next.ovf_ie = st_reg.w_data[BIT_OVERFLOW];
          end
        end
        OFS_COUNT_LOW, OFS_COUNT_HIGH: begin
          st_next.bresp = RESP_OKAY;
        end
        default: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid & i_s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Overflow set wins over a clear in the same cycle
    if (wrap) begin
      st_next.ovf = 1'b1;
    end

    // Read channel; low byte read snapshots the high byte in wide mode
    if (st_reg.rvalid & i_s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (do_read) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = 8'h00;
      unique case (i_s_axi_araddr)
        OFS_CONTROL: begin
          st_next.rdata = st_reg.ctrl;
          st_next.rdata[BIT_SYSCLK_OSC] = sysclk_osc_sync[0];
        end
        OFS_COUNT_LOW: begin
          st_next.rdata = st_reg.count[7:0];
          if (wide) begin
            st_next.hbuf = st_reg.count[15:8];
          end
        end
        OFS_COUNT_HIGH: begin
          st_next.rdata = wide ? st_reg.hbuf : st_reg.count[15:8];
        end
        OFS_FLAGS: begin
          st_next.rdata[BIT_OVERFLOW] = st_reg.ovf;
        end
        OFS_IRQ_EN: begin
          st_next.rdata[BIT_OVERFLOW] = st_reg.ovf_ie;
        end
        default: begin
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.ctrl  <= CONTROL_RESET;
      st_reg.count <= COUNT_RESET;
      st_reg.hbuf  <= BUF_RESET;
      st_reg.presc <= PRESC_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_s_axi_awready = ~st_reg.aw_full;
  assign o_s_axi_wready  = ~st_reg.w_full;
  assign o_s_axi_bvalid  = st_reg.bvalid;
  assign o_s_axi_bresp   = st_reg.bresp;
  assign o_s_axi_arready = ~st_reg.rvalid;
  assign o_s_axi_rvalid  = st_reg.rvalid;
  assign o_s_axi_rdata   = {24'h000000, st_reg.rdata};
  assign o_s_axi_rresp   = st_reg.rresp;

  assign o_overflow_flag = st_reg.ovf;
  assign o_overflow_irq  = st_reg.ovf & st_reg.ovf_ie;

endmodule
`default_nettype wire

// ### src/sbtc_pkg.sv
// Constants of the sixteen-bit timer/counter: register map, fields and reset values.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned addresses.
package sbtc_pkg;

  localparam int unsigned ADDR_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT_LOW = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH= 5'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 5'h10;

  // Control field positions, then the overflow bit of the flag and enable registers
  localparam int unsigned BIT_WIDE_ACCESS = 7;
  localparam int unsigned BIT_SYSCLK_OSC  = 6;
  localparam int unsigned BIT_PRESC_HI    = 5;
  localparam int unsigned BIT_PRESC_LO    = 4;
  localparam int unsigned BIT_OSC_EN      = 3;
  localparam int unsigned BIT_SYNC_DIS    = 2;
  localparam int unsigned BIT_SRC_SEL     = 1;
  localparam int unsigned BIT_RUN         = 0;
  localparam int unsigned BIT_OVERFLOW    = 0;

  // Control bits that software may write; bit 6 is read-only status
  localparam logic [7:0] CONTROL_WMASK = 8'hbf;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [7:0] BUF_RESET     = 8'h00;
  localparam logic [2:0] PRESC_RESET   = 3'h0;

  // Compare unit mode that issues the special event trigger
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hb;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### src/sbtc_edge_if.sv
// Carries the count clock level, its sync choice and the detected rising edge.
// Assumes both ends share i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface sbtc_edge_if;
  logic raw;
  logic sync_bypass;
  logic rise;
  modport detector (input raw, input sync_bypass, output rise);
  modport user     (output raw, output sync_bypass, input rise);
endinterface
`default_nettype wire

// ### src/sbtc_edge.sv
// Pin synchroniser and rising-edge finder for the external count clock.
// Assumes the count clock is far slower than i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sbtc_edge
  import sbtc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  sbtc_edge_if.detector   edge_bus
);
  import sbtc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sbtc_edge_state_t;

  sbtc_edge_state_t st_reg;
  sbtc_edge_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = edge_bus.raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Level only moves once two stages agree, filtering a metastable sample
    if (st_reg.s2 == st_reg.s3) begin
      st_next.level = st_reg.s3;
    end
  end

  // Bypass path answers one cycle sooner but skips the agreement filter
  assign edge_bus.rise = edge_bus.sync_bypass ? (st_reg.s2 & ~st_reg.s3)
                                              : (st_reg.s2 & st_reg.s3 & ~st_reg.level);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule
`default_nettype wire

// ### tb/sbtc_chk.sv
// Port-level assertions for the sixteen-bit timer/counter.
// Assumes it is bound to sbtc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sbtc_chk
  import sbtc_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_arst_n,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_arready,
  input wire logic        o_crystal_osc_enable,
  input wire logic        o_crystal_in_pin_oe_n,
  input wire logic        o_crystal_out_pin_oe_n,
  input wire logic [1:0]  o_port_read,
  input wire logic        i_compare_trigger,
  input wire logic [3:0]  i_compare_unit_mode,
  input wire logic        i_adc_enable,
  input wire logic        o_adc_start,
  input wire logic        o_overflow_flag,
  input wire logic        o_overflow_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  a_adc_start: assert property (
    o_adc_start == (i_compare_trigger && i_adc_enable
                    && i_compare_unit_mode == SPECIAL_EVENT_MODE))
    else $error("conversion start does not follow trigger");
  a_irq_needs_flag: assert property (
    o_overflow_irq |-> o_overflow_flag)
    else $error("interrupt without overflow flag");
  a_osc_pins_input: assert property (
    o_crystal_osc_enable |-> o_crystal_in_pin_oe_n && o_crystal_out_pin_oe_n)
    else $error("pin driven while oscillator on");
  // Zero is forced after the filter; the check still starts after four cycles of oscillator on
  a_port_read_zero: assert property (
    o_crystal_osc_enable [*4] |-> o_port_read == 2'h0)
    else $error("pin readback not zero with oscillator on");
  a_bvalid_hold: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer dropped early");
  a_rdata_byte: assert property (
    o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_ar_blocked: assert property (
    o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("address taken while answer pending");
endmodule

bind sbtc_top sbtc_chk i_chk (.i_sys_clk, .i_arst_n, .o_s_axi_bvalid, .i_s_axi_bready,
  .o_s_axi_bresp, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_arready,
  .o_crystal_osc_enable, .o_crystal_in_pin_oe_n, .o_crystal_out_pin_oe_n, .o_port_read,
  .i_compare_trigger, .i_compare_unit_mode, .i_adc_enable, .o_adc_start,
  .o_overflow_flag, .o_overflow_irq);
`default_nettype wire

// ### tb/sbtc_ext_model.sv
// External count clock pin and low-speed oscillator output.
// Assumes bursts far slower than i_sys_clk; both lines rest low.
`timescale 1ns/1ps
`default_nettype none
module sbtc_ext_model (
  input  wire logic i_sys_clk,
  output logic      o_pin,
  output logic      o_osc
);
  initial begin
    o_pin = 1'b0;
    o_osc = 1'b0;
  end

  // Slow edges so the synchroniser never misses one
  task automatic burst(input logic sel, input int n);
    repeat (n) begin
      repeat (6) @(posedge i_sys_clk);
      if (sel) o_osc <= 1'b1;
      else o_pin <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      o_osc <= 1'b0;
      o_pin <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the sixteen-bit timer/counter.
// Assumes sbtc_top, its package and the external clock model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbtc_pkg::*;
  logic        clk, rst_n, awv, wv, bry, arv, rry, trig, adc_en, sys_osc;
  logic [4:0]  awa, ara;
  logic [31:0] wd, rdata, d;
  logic [3:0]  mode;
  logic [1:0]  dir, bresp, rresp, r, pread;
  logic        awrdy, wrdy, bv, arrdy, rv, xin_o, xin_oe, xout_o, xout_oe;
  logic        osc_en, adc_st, ovf, irq, pin, oscc, race;
  wire logic   xin_w, xout_w;
  int          num_errors, cmp_count;

  // Pin level from whoever drives it; idle in pin pulled low, idle out pin follows the model pin
  assign xin_w  = !xin_oe ? xin_o : 1'b0;
  assign xout_w = !xout_oe ? xout_o : pin;

  sbtc_top i_dut (.i_sys_clk(clk), .i_arst_n(rst_n),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awrdy),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'h1), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arrdy), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .i_crystal_in_pin(xin_w), .o_crystal_in_pin(xin_o), .o_crystal_in_pin_oe_n(xin_oe),
    .i_crystal_out_pin(xout_w), .o_crystal_out_pin(xout_o),
    .o_crystal_out_pin_oe_n(xout_oe), .i_port_dir_input(dir), .i_port_latch(2'h3),
    .o_port_read(pread), .i_osc_clk(oscc), .o_crystal_osc_enable(osc_en),
    .i_sysclk_from_timer_osc(sys_osc), .i_compare_unit_mode(mode),
    .i_compare_trigger(trig), .i_adc_enable(adc_en), .o_adc_start(adc_st),
    .o_overflow_flag(ovf), .o_overflow_irq(irq));

  sbtc_ext_model i_ext (.i_sys_clk(clk), .o_pin(pin), .o_osc(oscc));

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    bit ta;
    bit tw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awrdy) begin
        ta = 1;
        awv <= 1'b0;
      end
      if (!tw && wrdy) begin
        tw = 1;
        wv <= 1'b0;
      end
    end
    // Optional trigger lands on the commit edge, one after both are taken
    trig <= race;
    @(posedge clk);
    trig <= 1'b0;
    while (!bv) @(posedge clk);
    bry <= 1'b1;
    @(posedge clk);
    r = bresp;
    bry <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arrdy);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rry <= 1'b1;
    @(posedge clk);
    d = rdata;
    r = rresp;
    rry <= 1'b0;
  endtask

  task automatic rck(input logic [4:0] a, input logic [7:0] e);
    rd(a);
    chk({r, d}, {RESP_OKAY, 24'h0, e});
  endtask

  task automatic pulse(input logic [3:0] m, input logic en, input logic e);
    @(posedge clk);
    mode <= m;
    adc_en <= en;
    trig <= 1'b1;
    #1;
    chk(adc_st, e);
    @(posedge clk);
    trig <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_ctrl;
    rck(OFS_CONTROL, 8'h00);
    wr(OFS_CONTROL, 8'hfe);
    chk(r, RESP_OKAY);
    rck(OFS_CONTROL, 8'hbe);
    chk(osc_en, 1'b1);
    chk({xin_oe, xout_oe, pread}, 4'hc);
    sys_osc <= 1'b1;
    repeat (5) @(posedge clk);
    rck(OFS_CONTROL, 8'hfe);
    sys_osc <= 1'b0;
    wr(OFS_CONTROL, 8'h00);
    chk({osc_en, xin_oe, xout_oe}, 3'h0);
    rd(5'h14);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    chk(pread, 2'h3);
    wr(5'h14, 8'hff);
    chk(r, RESP_SLVERR);
  endtask

  task automatic t_presc;
    for (int p = 0; p < 4; p++) begin
      wr(OFS_COUNT_LOW, 8'h00);
      wr(OFS_COUNT_HIGH, 8'h00);
      wr(OFS_CONTROL, {2'b00, p[1:0], 4'h1});
      repeat (16 << p) @(posedge clk);
      wr(OFS_CONTROL, {2'b00, p[1:0], 4'h0});
      rd(OFS_COUNT_LOW);
      chk(d >= 16 && d <= 17 + (8 >> p), 1'b1);
      repeat (20) @(posedge clk);
      rck(OFS_COUNT_LOW, d[7:0]);
    end
  endtask

  task automatic t_ovf;
    wr(OFS_COUNT_HIGH, 8'hff);
    wr(OFS_COUNT_LOW, 8'hf0);
    chk(ovf, 1'b0);
    wr(OFS_CONTROL, 8'h01);
    repeat (30) @(posedge clk);
    wr(OFS_CONTROL, 8'h00);
    chk({ovf, irq}, 2'h2);
    rck(OFS_COUNT_HIGH, 8'h00);
    wr(OFS_IRQ_EN, 8'h01);
    chk(irq, 1'b1);
    wr(OFS_FLAGS, 8'h01);
    chk({ovf, irq}, 2'h0);
  endtask

  task automatic t_trig;
    wr(OFS_COUNT_HIGH, 8'hff);
    wr(OFS_COUNT_LOW, 8'hff);
    pulse(4'ha, 1'b1, 1'b0);
    rck(OFS_COUNT_LOW, 8'hff);
    pulse(SPECIAL_EVENT_MODE, 1'b0, 1'b0);
    rck(OFS_COUNT_LOW, 8'h00);
    rck(OFS_COUNT_HIGH, 8'h00);
    chk(ovf, 1'b0);
    wr(OFS_CONTROL, 8'h06);
    wr(OFS_COUNT_LOW, 8'h55);
    pulse(SPECIAL_EVENT_MODE, 1'b1, 1'b1);
    rck(OFS_COUNT_LOW, 8'h55);
    wr(OFS_CONTROL, 8'h00);
  endtask

  task automatic t_wide;
    wr(OFS_COUNT_HIGH, 8'h12);
    wr(OFS_COUNT_LOW, 8'h34);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_COUNT_HIGH, 8'h56);
    rck(OFS_COUNT_HIGH, 8'h56);
    wr(OFS_CONTROL, 8'h00);
    rck(OFS_COUNT_HIGH, 8'h12);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_COUNT_LOW, 8'h78);
    wr(OFS_CONTROL, 8'h00);
    rck(OFS_COUNT_HIGH, 8'h56);
    wr(OFS_COUNT_HIGH, 8'h9a);
    wr(OFS_CONTROL, 8'h80);
    rck(OFS_COUNT_LOW, 8'h78);
    rck(OFS_COUNT_HIGH, 8'h9a);
    wr(OFS_CONTROL, 8'h00);
  endtask

  task automatic t_ext;
    logic [7:0] c;
    dir <= 2'h3;
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 8'h03 : (i == 1) ? 8'h07 : 8'h0b;
      wr(OFS_COUNT_LOW, 8'h00);
      wr(OFS_CONTROL, c);
      // Oscillator start-up wait before the first edge
      repeat (40) @(posedge clk);
      i_ext.burst(c[3], 5);
      i_ext.burst(!c[3], 3);
      repeat (10) @(posedge clk);
      wr(OFS_CONTROL, 8'h00);
      rck(OFS_COUNT_LOW, 8'h05);
    end
  endtask

  task automatic t_race;
    mode <= SPECIAL_EVENT_MODE;
    wr(OFS_COUNT_HIGH, 8'h33);
    race = 1'b1;
    wr(OFS_COUNT_LOW, 8'h44);
    race = 1'b0;
    rck(OFS_COUNT_LOW, 8'h44);
    rck(OFS_COUNT_HIGH, 8'h00);
  endtask

  // Each run window is five ticks at 1:8, so only a kept prescaler count reaches a step
  task automatic t_presc_clr;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) wr(OFS_COUNT_HIGH, 8'h00);
      else wr(OFS_COUNT_LOW, 8'h00);
      wr(OFS_CONTROL, 8'h31);
      wr(OFS_CONTROL, 8'h30);
      rck(OFS_COUNT_LOW, (k == 2) ? 8'h01 : 8'h00);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {rst_n, awv, wv, bry, arv, rry, trig, adc_en, sys_osc, race} = '0;
    {awa, ara, wd, mode, dir} = '0;
    num_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_ctrl;
    t_presc;
    t_presc_clr;
    t_ovf;
    t_trig;
    t_race;
    t_wide;
    t_ext;
    print_verdict;
  end

  // Whole run needs under two thousand cycles
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
